// file: dv/fifo_bus_props.sv
// Wire checks on the FIFO bus between both ends
module fifo_bus_props #(
    parameter int W = 32
) (
    input wire logic           clk,
    input wire logic           resetn,
    input wire logic           bus_clk,
    input wire logic [W-1:0]   data_dev_oe,
    input wire logic [W/8-1:0] be_dev_oe,
    input wire logic           tx_space_n,
    input wire logic           rx_avail_n,
    input wire logic           wr_n,
    input wire logic           oe_n,
    input wire logic           cfg_pin_hi,
    input wire logic           cfg_pin_lo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic multi;
    assign multi = cfg_pin_hi | cfg_pin_lo;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence half_hi;
        bus_clk [*4] ##1 !bus_clk;
    endsequence
    sequence half_lo;
        !bus_clk [*4] ##1 bus_clk;
    endsequence
    clk_high_a: assert property ($rose(bus_clk) |-> half_hi)
        else $error("bus clock high half wrong");
    clk_low_a: assert property ($fell(bus_clk) |-> half_lo)
        else $error("bus clock low half wrong");
    oe_off_a: assert property ((!multi && oe_n) [*5] |-> data_dev_oe == '0 && be_dev_oe == '0)
        else $error("bus driven without enable");
    oe_on_a: assert property ((!multi && !oe_n) [*5] |-> data_dev_oe == '1 && be_dev_oe == '1)
        else $error("bus not driven under enable");
    status_edge_a: assert property ($changed(rx_avail_n) || $changed(tx_space_n) |-> $rose(bus_clk))
        else $error("status moved off a bus clock rise");
    ack_start_a: assert property (multi && $fell(rx_avail_n) |-> !$past(wr_n, 3))
        else $error("acknowledge without request");
    ack_end_a: assert property (multi && $rose(rx_avail_n) |-> $past(wr_n, 3))
        else $error("acknowledge ended under request");
    valid_phase_a: assert property (multi && !tx_space_n && !wr_n |-> !rx_avail_n)
        else $error("status valid outside data phase");
    idle_status_a: assert property ((multi && rx_avail_n) [*8] |-> data_dev_oe[15:8] == 8'hff)
        else $error("idle status not driven");
endmodule // fifo_bus_props

// file: dv/tb_sync_fifo_slave_bus_port.sv
// Both bus ends joined through the interface, tested from the user sides
module tb_sync_fifo_slave_bus_port
    import bus_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEPTH = 4;
    logic        clk = 1'h0, resetn = 1'h0, clk_fast = 1'h1, strap_hi = 1'h0, strap_lo = 1'h0, seen = 1'h0;
    logic        rx_push_valid = 1'h0, tx_pop_ready = 1'h0, suspended = 1'h0, remote_wake_en = 1'h0;
    logic        wake_req = 1'h0, wr_valid = 1'h0, rd_enable = 1'h0, cmd_valid = 1'h0, cmd_write = 1'h0;
    logic [31:0] rx_push_data = '0, wr_data = '0;
    logic [3:0]  wr_be = '0;
    logic [7:0]  cmd_chan = '0;
    logic        rx_push_ready, tx_pop_valid, resume_req, wr_taken, rd_valid, busy;
    logic [31:0] tx_pop_data, rd_data;
    logic [3:0]  tx_pop_be;
    logic [7:0]  chan_status;
    mode_t       mode;
    int          num_errors = 0, n_tests = 0;

    always #10 clk = ~clk;

    fifo_bus_if #(.W(32)) fifo_bus_if_i ();
    fifo_bus_device #(.W(32), .DEPTH(DEPTH)) fifo_bus_device_i (.clk, .resetn, .bus(fifo_bus_if_i), .clk_fast,
        .rx_push_valid, .rx_push_data, .rx_push_ready, .tx_pop_valid, .tx_pop_data, .tx_pop_be, .tx_pop_ready,
        .suspended, .remote_wake_en, .resume_req, .mode);
    fifo_bus_master #(.W(32)) fifo_bus_master_i (.clk, .resetn, .bus(fifo_bus_if_i), .strap_hi, .strap_lo,
        .wr_valid, .wr_data, .wr_be, .wr_taken, .rd_enable, .rd_valid, .rd_data, .cmd_valid, .cmd_write,
        .cmd_chan, .busy(), .chan_status, .wake_req);
    fifo_bus_props #(.W(32)) fifo_bus_props_i (.clk, .resetn, .bus_clk(fifo_bus_if_i.bus_clk),
        .data_dev_oe(fifo_bus_if_i.data_dev_oe), .be_dev_oe(fifo_bus_if_i.be_dev_oe),
        .tx_space_n(fifo_bus_if_i.tx_space_n), .rx_avail_n(fifo_bus_if_i.rx_avail_n), .wr_n(fifo_bus_if_i.wr_n),
        .oe_n(fifo_bus_if_i.oe_n), .cfg_pin_hi(fifo_bus_if_i.cfg_pin_hi), .cfg_pin_lo(fifo_bus_if_i.cfg_pin_lo));

    task automatic print_verdict();
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic await(ref logic s);
        int t;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (s !== 1'h1 && t < 600);
        if (s !== 1'h1) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic rst(input logic h, input logic l);
        resetn <= 1'h0;
        strap_hi <= h;
        strap_lo <= l;
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        repeat (40) @(posedge clk);
    endtask
    // Senders leave valid up; the caller drops it after a batch
    task automatic send(input logic [31:0] d, input logic [3:0] b);
        wr_valid <= 1'h1;
        wr_data <= d;
        wr_be <= b;
        await(wr_taken);
    endtask
    task automatic push(input logic [31:0] d);
        rx_push_valid <= 1'h1;
        rx_push_data <= d;
        await(rx_push_ready);
    endtask
    task automatic pop(input logic [31:0] d, input logic [3:0] b);
        tx_pop_ready <= 1'h1;
        await(tx_pop_valid);
        chk(tx_pop_data, d);
        chk(tx_pop_be, b);
    endtask
    task automatic recv(input logic [31:0] d);
        await(rd_valid);
        chk(rd_data, d);
    endtask
    task automatic start(input logic [7:0] ch, input logic w);
        cmd_chan <= ch;
        cmd_write <= w;
        cmd_valid <= 1'h1;
    endtask

    initial begin
        rst(1'h0, 1'h0);
        chk(mode, MODE_SINGLE);
        chk({fifo_bus_if_i.tx_space_n, fifo_bus_if_i.rx_avail_n}, 2'h1);
        for (int i = 0; i < DEPTH + 1; i++) send(32'ha0 + i, 4'(i + 1));
        wr_valid <= 1'h0;
        repeat (40) @(posedge clk);
        chk(fifo_bus_if_i.tx_space_n, 1'h1);
        for (int i = 0; i < DEPTH + 1; i++) pop(32'ha0 + i, 4'(i + 1));
        tx_pop_ready <= 1'h0;
        for (int i = 0; i < DEPTH; i++) push(32'hb0 + i);
        rx_push_valid <= 1'h0;
        repeat (40) @(posedge clk);
        chk(fifo_bus_if_i.rx_avail_n, 1'h0);
        rd_enable <= 1'h1;
        for (int i = 0; i < DEPTH; i++) recv(32'hb0 + i);
        rd_enable <= 1'h0;
        repeat (40) @(posedge clk);
        chk({fifo_bus_if_i.rx_avail_n, fifo_bus_if_i.data_dev_oe[0]}, 2'h2);
        suspended <= 1'h1;
        remote_wake_en <= 1'h1;
        wake_req <= 1'h1;
        await(resume_req);
        wake_req <= 1'h0;
        remote_wake_en <= 1'h0;
        repeat (10) @(posedge clk);
        wake_req <= 1'h1;
        repeat (20) begin
            @(posedge clk);
            seen |= resume_req;
        end
        chk(seen, 1'h0);
        for (int m = 1; m < 4; m++) begin
            rst(m[1], m[0]);
            chk(mode, m);
        end
        push(32'hc5);
        rx_push_valid <= 1'h0;
        repeat (40) @(posedge clk);
        chk(chan_status, 8'hee);
        start(8'h1, 1'h1);
        send(32'hd1, 4'hf);
        send(32'hd2, 4'hf);
        wr_valid <= 1'h0;
        cmd_valid <= 1'h0;
        repeat (40) @(posedge clk);
        pop(32'hd1, 4'hf);
        pop(32'hd2, 4'hf);
        tx_pop_ready <= 1'h0;
        start(8'h1, 1'h0);
        recv(32'hc5);
        cmd_valid <= 1'h0;
        repeat (40) @(posedge clk);
        start(8'h2, 1'h1);
        send(32'he0, 4'hf);
        wr_valid <= 1'h0;
        cmd_valid <= 1'h0;
        repeat (40) @(posedge clk);
        chk(tx_pop_valid, 1'h0);
        push(32'h1);
        rx_push_valid <= 1'h0;
        rst(1'h0, 1'h0);
        chk({fifo_bus_if_i.rx_avail_n, tx_pop_valid}, 2'h2);
        print_verdict();
    end
endmodule // tb_sync_fifo_slave_bus_port

// file: verilog/bus_port_pkg.sv
// Types used by the two ends of the FIFO bus
package bus_port_pkg;
    typedef enum logic [1:0] {MODE_SINGLE, MODE_MULTI1, MODE_MULTI2, MODE_MULTI4} mode_t;
    typedef enum logic {ST_IDLE, ST_DATA} dev_state_t;
    typedef enum logic [1:0] {HS_IDLE, HS_ACK, HS_DATA, HS_END} host_state_t;
endpackage

// file: verilog/bus_port_regs.svh
// Shared constants of the synchronous FIFO bus port
`ifndef BUS_PORT_REGS_SVH
`define BUS_PORT_REGS_SVH

`define CLK_PERIOD_NS      20
`define BUS_PERIOD_FAST_NS 160
`define BUS_PERIOD_SLOW_NS 240
`define HALF_FAST          ((`BUS_PERIOD_FAST_NS / `CLK_PERIOD_NS) / 2)
`define HALF_SLOW          ((`BUS_PERIOD_SLOW_NS / `CLK_PERIOD_NS) / 2)
`define STRAP_CYCLE        2'h2
`define CMD_DIR_BIT        0
`define CHAN_MSB           7
`define CHAN_ONE           8'h01
`define STAT_LSB           8
`define STAT_OUT_BIT       12
`define STAT_IN_BIT        8
`define STAT_FIELD         8'hff

`endif

// file: verilog/fifo_bus_device.sv
// Bus slave end of the synchronous FIFO bus with its receive and transmit buffers
module fifo_bus_device
    import bus_port_pkg::*;
#(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    fifo_bus_if.device        bus,
    input  wire logic         clk_fast,
    input  wire logic         rx_push_valid,
    input  wire logic [W-1:0] rx_push_data,
    output logic              rx_push_ready,
    output logic              tx_pop_valid,
    output logic [W-1:0]      tx_pop_data,
    output logic [W/8-1:0]    tx_pop_be,
    input  wire logic         tx_pop_ready,
    input  wire logic         suspended,
    input  wire logic         remote_wake_en,
    output logic              resume_req,
    output mode_t             mode
);
    `include "bus_port_regs.svh"

    localparam int BW = W / 8;
    localparam int AW = $clog2(DEPTH);
    localparam int SW = W + BW + 6;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [W-1:0] STAT_MASK = W'(`STAT_FIELD) << `STAT_LSB;

    if ((W != 16 && W != 32) || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
        $error("fifo_bus_device needs W of 16 or 32 and a power-of-two DEPTH");
    end

    function automatic logic [AW:0] next_count(input logic [AW:0] cnt, input logic inc, input logic dec);
        next_count = cnt + (AW + 1)'(inc) - (AW + 1)'(dec);
    endfunction

    logic [SW-1:0]     pins_raw;
    logic [SW-1:0]     pins_s;
    logic              wr_s;
    logic              rd_s;
    logic              oe_s;
    logic              wake_s;
    logic [W-1:0]      data_s;
    logic [BW-1:0]     be_s;
    logic [3:0]        div_cnt;
    logic [3:0]        half_m1;
    logic              bus_clk;
    logic              rise;
    logic [1:0]        strap_cnt;
    logic              multi;
    dev_state_t        state;
    dev_state_t        next_state;
    logic              cmd_write;
    logic [7:0]        cmd_chan;
    logic [W-1:0]      rx_mem [DEPTH];
    logic [W+BW-1:0]   tx_mem [DEPTH];
    logic [AW-1:0]     rx_wr;
    logic [AW-1:0]     rx_rd;
    logic [AW-1:0]     tx_wr;
    logic [AW-1:0]     tx_rd;
    logic [AW:0]       rx_count;
    logic [AW:0]       tx_count;
    logic [AW:0]       next_rx_count;
    logic [AW:0]       next_tx_count;
    logic              rx_push;
    logic              rx_pop;
    logic              tx_push;
    logic              tx_pop;
    logic              mread_hit;
    logic              mwrite_hit;
    logic              wake_prev;
    logic [W-1:0]      data_dev;
    logic [W-1:0]      data_dev_oe;
    logic [BW-1:0]     be_dev;
    logic [BW-1:0]     be_dev_oe;
    logic              tx_space_n;
    logic              rx_avail_n;

    assign pins_raw = {bus.wr_n, bus.rd_n, bus.oe_n, bus.wake_n, bus.cfg_pin_hi, bus.cfg_pin_lo, bus.be, bus.data};

    pin_sync #(.WIDTH(SW)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (pins_raw),
        .dout   (pins_s)
    );

    assign wr_s   = pins_s[SW-1];
    assign rd_s   = pins_s[SW-2];
    assign oe_s   = pins_s[SW-3];
    assign wake_s = pins_s[SW-4];
    assign be_s   = pins_s[W+BW-1:W];
    assign data_s = pins_s[W-1:0];
    assign multi  = mode != MODE_SINGLE;

    // Bus clock divided down from the core clock
    assign half_m1 = clk_fast ? 4'(`HALF_FAST - 1) : 4'(`HALF_SLOW - 1);
    assign rise    = div_cnt == half_m1 && !bus_clk;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_cnt <= '0;
            bus_clk <= 1'b0;
        end else if (div_cnt >= half_m1) begin
            div_cnt <= '0;
            bus_clk <= ~bus_clk;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    assign bus.bus_clk = bus_clk;

    // Mode strap taken once the synchronised pins have settled
    always_ff @(posedge clk) begin
        if (!resetn) begin
            strap_cnt <= '0;
            mode      <= MODE_SINGLE;
        end else begin
            if (strap_cnt != 2'h3) begin
                strap_cnt <= strap_cnt + 2'h1;
            end
            if (strap_cnt == `STRAP_CYCLE) begin
                mode <= mode_t'({pins_s[SW-5], pins_s[SW-6]});
            end
        end
    end

    // Bus transfers sampled at each bus clock rise; user-side push and pop on any core clock
    always_comb begin
        mread_hit  = rise && multi && state == ST_DATA && !wr_s && cmd_chan == `CHAN_ONE && !cmd_write;
        mwrite_hit = rise && multi && state == ST_DATA && !wr_s && cmd_chan == `CHAN_ONE && cmd_write;
        rx_pop     = (rise && !multi && !rd_s && !oe_s && rx_count != '0)
                   || (mread_hit && rx_count != '0);
        tx_push    = (rise && !multi && !wr_s && tx_count != FULL)
                   || (mwrite_hit && tx_count != FULL);
        rx_push    = rx_push_valid && rx_push_ready;
        tx_pop     = tx_count != '0 && (!tx_pop_valid || tx_pop_ready);
        next_rx_count = next_count(rx_count, rx_push, rx_pop);
        next_tx_count = next_count(tx_count, tx_push, tx_pop);
        next_state = state;
        if (rise && multi) begin
            case (state)
                ST_IDLE: begin
                    if (!wr_s) begin
                        next_state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (wr_s) begin
                        next_state = ST_IDLE;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state     <= ST_IDLE;
            cmd_write <= 1'b0;
            cmd_chan  <= '0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && next_state == ST_DATA) begin
                cmd_write <= be_s[`CMD_DIR_BIT];
                cmd_chan  <= data_s[`CHAN_MSB:0];
            end
        end
    end

    // Receive buffer filled by the user side, transmit buffer filled from the bus
    always_ff @(posedge clk) begin
        if (rx_push) begin
            rx_mem[rx_wr] <= rx_push_data;
        end
        if (tx_push) begin
            tx_mem[tx_wr] <= {be_s, data_s};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_wr         <= '0;
            rx_rd         <= '0;
            rx_count      <= '0;
            rx_push_ready <= 1'b0;
        end else begin
            rx_wr         <= rx_push ? rx_wr + 1'b1 : rx_wr;
            rx_rd         <= rx_pop ? rx_rd + 1'b1 : rx_rd;
            rx_count      <= next_rx_count;
            rx_push_ready <= next_rx_count != FULL;
        end
    end

    // Transmit buffer, drained through an output register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_wr        <= '0;
            tx_rd        <= '0;
            tx_count     <= '0;
            tx_pop_valid <= 1'b0;
            tx_pop_data  <= '0;
            tx_pop_be    <= '0;
        end else begin
            tx_wr    <= tx_push ? tx_wr + 1'b1 : tx_wr;
            tx_rd    <= tx_pop ? tx_rd + 1'b1 : tx_rd;
            tx_count <= next_tx_count;
            if (tx_pop) begin
                tx_pop_valid <= 1'b1;
                {tx_pop_be, tx_pop_data} <= tx_mem[tx_rd];
            end else if (tx_pop_ready) begin
                tx_pop_valid <= 1'b0;
            end
        end
    end

    // Bus drivers and status outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_dev    <= '0;
            data_dev_oe <= '0;
            be_dev      <= '0;
            be_dev_oe   <= '0;
            tx_space_n  <= 1'b1;
            rx_avail_n  <= 1'b1;
        end else begin
            be_dev <= '1;
            if (rx_pop) begin
                data_dev <= rx_mem[rx_rd];
            end else if (rise && multi) begin
                data_dev <= ~STAT_MASK | ~(W'(next_rx_count != '0) << `STAT_OUT_BIT)
                          & ~(W'(next_tx_count != FULL) << `STAT_IN_BIT);
            end
            if (!multi) begin
                data_dev_oe <= {W{!oe_s}};
                be_dev_oe   <= {BW{!oe_s}};
                rx_avail_n  <= rise ? next_rx_count == '0 : rx_avail_n;
                tx_space_n  <= rise ? next_tx_count == FULL : tx_space_n;
            end else begin
                data_dev_oe <= state == ST_IDLE ? STAT_MASK : {W{state == ST_DATA && !cmd_write}};
                be_dev_oe   <= {BW{state == ST_DATA && !cmd_write}};
                rx_avail_n  <= next_state != ST_DATA;
                if (rise) begin
                    tx_space_n <= !(mread_hit && rx_count != '0);
                end
            end
        end
    end

    assign bus.data_dev    = data_dev;
    assign bus.data_dev_oe = data_dev_oe;
    assign bus.be_dev      = be_dev;
    assign bus.be_dev_oe   = be_dev_oe;
    assign bus.tx_space_n  = tx_space_n;
    assign bus.rx_avail_n  = rx_avail_n;

    // Resume request on the falling edge of the wake-up pin
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wake_prev  <= 1'b1;
            resume_req <= 1'b0;
        end else begin
            wake_prev  <= wake_s;
            resume_req <= suspended && remote_wake_en && wake_prev && !wake_s;
        end
    end
endmodule // fifo_bus_device

// file: verilog/fifo_bus_if.sv
// Pins of the FIFO bus with wire resolution of the shared lines
interface fifo_bus_if #(parameter int W = 32);
    localparam int BW = W / 8;
    logic          bus_clk;
    logic [W-1:0]  data_dev;
    logic [W-1:0]  data_dev_oe;
    logic [W-1:0]  data_host;
    logic [W-1:0]  data_host_oe;
    logic [W-1:0]  data;
    logic [BW-1:0] be_dev;
    logic [BW-1:0] be_dev_oe;
    logic [BW-1:0] be_host;
    logic [BW-1:0] be_host_oe;
    logic [BW-1:0] be;
    logic          tx_space_n;
    logic          rx_avail_n;
    logic          wr_n;
    logic          rd_n;
    logic          oe_n;
    logic          wake_n;
    logic          cfg_pin_hi;
    logic          cfg_pin_lo;

    // Undriven lines float high through the board pull-ups
    assign data = (data_dev & data_dev_oe) | (data_host & data_host_oe) | ~(data_dev_oe | data_host_oe);
    assign be   = (be_dev & be_dev_oe) | (be_host & be_host_oe) | ~(be_dev_oe | be_host_oe);

    modport device (output bus_clk, data_dev, data_dev_oe, be_dev, be_dev_oe, tx_space_n, rx_avail_n,
                    input data, be, wr_n, rd_n, oe_n, wake_n, cfg_pin_hi, cfg_pin_lo);
    modport host (input bus_clk, data, be, tx_space_n, rx_avail_n,
                  output data_host, data_host_oe, be_host, be_host_oe, wr_n, rd_n, oe_n, wake_n,
                  cfg_pin_hi, cfg_pin_lo);
endinterface

// file: verilog/fifo_bus_master.sv
// Bus master end of the synchronous FIFO bus
module fifo_bus_master
    import bus_port_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic           clk,
    input  wire logic           resetn,
    fifo_bus_if.host            bus,
    input  wire logic           strap_hi,
    input  wire logic           strap_lo,
    input  wire logic           wr_valid,
    input  wire logic [W-1:0]   wr_data,
    input  wire logic [W/8-1:0] wr_be,
    output logic                wr_taken,
    input  wire logic           rd_enable,
    output logic                rd_valid,
    output logic [W-1:0]        rd_data,
    input  wire logic           cmd_valid,
    input  wire logic           cmd_write,
    input  wire logic [7:0]     cmd_chan,
    output logic                busy,
    output logic [7:0]          chan_status,
    input  wire logic           wake_req
);
    `include "bus_port_regs.svh"

    localparam int BW = W / 8;
    localparam int SW = W + BW + 3;
    localparam logic [W-1:0] STAT_MASK = W'(`STAT_FIELD) << `STAT_LSB;

    if (W != 16 && W != 32) begin : g_check
        $error("fifo_bus_master needs W of 16 or 32");
    end

    logic [SW-1:0] pins_s;
    logic          clk_s;
    logic          clk_prev;
    logic          rise;
    logic          avail_s;
    logic          space_s;
    logic [W-1:0]  data_s;
    logic          multi;
    logic          h_write;
    host_state_t   state;
    logic          wr_n;
    logic          rd_n;
    logic          oe_n;
    logic [W-1:0]  data_host;
    logic [W-1:0]  data_host_oe;
    logic [BW-1:0] be_host;
    logic [BW-1:0] be_host_oe;
    logic          wake_n;
    logic          cfg_hi;
    logic          cfg_lo;

    pin_sync #(.WIDTH(SW)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({bus.bus_clk, bus.rx_avail_n, bus.tx_space_n, bus.be, bus.data}),
        .dout   (pins_s)
    );

    assign clk_s   = pins_s[SW-1];
    assign avail_s = pins_s[SW-2];
    assign space_s = pins_s[SW-3];
    assign data_s  = pins_s[W-1:0];
    assign rise    = clk_s && !clk_prev;
    assign multi   = cfg_hi || cfg_lo;

    // Straps stay driven through reset so the device latches them settled
    always_ff @(posedge clk) begin
        cfg_hi <= strap_hi;
        cfg_lo <= strap_lo;
        if (!resetn) begin
            clk_prev <= 1'b1;
            wake_n   <= 1'b1;
        end else begin
            clk_prev <= clk_s;
            wake_n   <= !wake_req;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state        <= HS_IDLE;
            h_write      <= 1'b0;
            wr_n         <= 1'b1;
            rd_n         <= 1'b1;
            oe_n         <= 1'b1;
            data_host    <= '0;
            data_host_oe <= '0;
            be_host      <= '0;
            be_host_oe   <= '0;
            wr_taken     <= 1'b0;
            rd_valid     <= 1'b0;
            rd_data      <= '0;
            busy         <= 1'b0;
            chan_status  <= 8'hff;
        end else begin
            wr_taken <= 1'b0;
            rd_valid <= 1'b0;
            busy     <= state != HS_IDLE;
            if (rise && !multi) begin
                rd_valid     <= !rd_n;
                rd_data      <= data_s;
                oe_n         <= !rd_enable;
                rd_n         <= !(rd_enable && !oe_n && !avail_s);
                if (!rd_enable && oe_n && wr_valid && !space_s) begin
                    wr_n         <= 1'b0;
                    data_host    <= wr_data;
                    be_host      <= wr_be;
                    data_host_oe <= '1;
                    be_host_oe   <= '1;
                    wr_taken     <= 1'b1;
                end else begin
                    wr_n         <= 1'b1;
                    data_host_oe <= '0;
                    be_host_oe   <= '0;
                end
            end else if (rise) begin
                rd_n <= 1'b1;
                oe_n <= 1'b1;
                case (state)
                    HS_IDLE: begin
                        chan_status  <= data_s[`STAT_LSB+7:`STAT_LSB];
                        data_host    <= '1;
                        data_host_oe <= ~STAT_MASK;
                        be_host      <= '1;
                        be_host_oe   <= '1;
                        if (cmd_valid) begin
                            wr_n                 <= 1'b0;
                            h_write              <= cmd_write;
                            data_host[`CHAN_MSB:0] <= cmd_chan;
                            data_host_oe         <= '1;
                            be_host              <= BW'(cmd_write);
                            state                <= HS_ACK;
                        end
                    end
                    HS_ACK, HS_DATA: begin
                        if (state == HS_DATA || !avail_s) begin
                            if (h_write) begin
                                if (cmd_valid && wr_valid) begin
                                    data_host <= wr_data;
                                    be_host   <= wr_be;
                                    wr_taken  <= 1'b1;
                                    state     <= HS_DATA;
                                end else begin
                                    wr_n  <= 1'b1;
                                    state <= HS_END;
                                end
                            end else begin
                                data_host_oe <= '0;
                                be_host_oe   <= '0;
                                rd_valid     <= !space_s;
                                rd_data      <= data_s;
                                wr_n         <= !cmd_valid;
                                state        <= cmd_valid ? HS_DATA : HS_END;
                            end
                        end
                    end
                    HS_END: begin
                        data_host    <= '1;
                        data_host_oe <= ~STAT_MASK;
                        be_host      <= '1;
                        be_host_oe   <= '1;
                        state        <= HS_IDLE;
                    end
                    default: state <= HS_IDLE;
                endcase
            end
        end
    end

    assign bus.wr_n         = wr_n;
    assign bus.rd_n         = rd_n;
    assign bus.oe_n         = oe_n;
    assign bus.data_host    = data_host;
    assign bus.data_host_oe = data_host_oe;
    assign bus.be_host      = be_host;
    assign bus.be_host_oe   = be_host_oe;
    assign bus.wake_n       = wake_n;
    assign bus.cfg_pin_hi   = cfg_hi;
    assign bus.cfg_pin_lo   = cfg_lo;
endmodule // fifo_bus_master

// file: verilog/pin_sync.sv
// Two-flop synchroniser for a group of pins
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_check
        $error("pin_sync needs WIDTH of at least 1");
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            // Idle high level of the bus pins, so no false strobe follows reset
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // pin_sync
